// ==== logic/kms_keypad_scanner.sv ====
// keypad matrix scanner with an axi4-lite register slave
//
// Behaviour
// - five column drive outputs, six row sense inputs; key at their crossing
// - scanning drives one column low at a time; low row means closed
// - hardware scanning is off after reset until scan-enable is set
// - all timing counts a 1 kHz tick, running only with tick enable set
// - waiting: all scanned columns low, any low row noticed, no column scanning
// - row low: wait one debounce, recheck; none low returns to waiting
// - debounce from a six-bit field, 4 ms to 256 ms in 4 ms steps
// - rows of a column checked, then next column in order, whole keypad
// - row check interval from a two-bit field, 1 to 4 ms
// - exactly one closed switch gives a valid key; more give none
// - columns follow the programmed order; row order is fixed
// - valid key latches column and row and raises the interrupt
// - scanning carries on without waiting for the interrupt service
// - after a result wait release, debounce, restart if not released
// - scan disabled: columns show the drive latch contents
// - bypass: firmware writes columns, reads live row levels
// - drive latch bits 4..0 map to columns, zero drives low
// - size register limits scanned rows and columns
// - debounce value times 4 ms, zero meaning 256 ms, press and release
// - sense register bits 5..0 map to rows, zero meaning low
module kms_keypad_scanner
    import kms_pkg::*;
#(
    parameter int TICK_CYCLES = KMS_TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [4:0] col_drive,
    input wire logic [5:0] row_sense,
    output logic key_irq
);

    localparam int DIVW = $clog2(TICK_CYCLES + 1);
    localparam logic [DIVW-1:0] DIV_LAST = DIVW'(TICK_CYCLES - 1);

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    function automatic logic [8:0] db_ticks(input logic [5:0] dbt);
        logic [6:0] steps;
        steps = (dbt == 6'h00) ? KMS_DB_ZERO_STEPS : {1'b0, dbt};
        return 9'(steps * KMS_DB_STEP_MS / KMS_TICK_MS);
    endfunction

    function automatic logic [8:0] sc_ticks(input logic [1:0] sct);
        logic [2:0] ms;
        ms = (sct == 2'h0) ? KMS_SCT_ZERO_MS : {1'b0, sct};
        return 9'(ms / KMS_TICK_MS);
    endfunction

    // zero or oversized counts fall back to the full matrix
    function automatic logic [2:0] clamp(input logic [2:0] n, input logic [2:0] max);
        return (n == 3'h0 || n > max) ? max : n;
    endfunction

    function automatic logic [4:0] one_low(input logic [2:0] idx);
        logic [4:0] m;
        m = KMS_DRIVE_RST;
        for (int i = 0; i < KMS_NCOL; i++) begin
            if (idx == 3'(i)) begin
                m[i] = 1'b0;
            end
        end
        return m;
    endfunction

    // rows need their own mask: the column helper stops at five bits
    function automatic logic [5:0] row_low(input logic [2:0] idx);
        logic [5:0] m;
        m = KMS_SENSE_RST;
        for (int i = 0; i < KMS_NROW; i++) begin
            if (idx == 3'(i)) begin
                m[i] = 1'b0;
            end
        end
        return m;
    endfunction

    // ------------------------------------------------------------
    // registers and shared signals
    // ------------------------------------------------------------
    logic [5:0] row_meta_r;
    logic [5:0] row_s_r;
    logic [4:0] drive_latch_reg_r;
    logic [5:0] sense_value_reg_r;
    logic [7:0] scan_timing_reg_r;
    logic [7:0] drive_order_low_reg_r;
    logic [11:0] drive_order_high_reg_r;
    logic [7:0] matrix_size_reg_r;
    logic [7:0] master_clock_ctrl_reg_r;
    logic hw_scan_enable_r;
    logic irq_enable_r;
    logic key_flag_r;
    logic [DIVW-1:0] div_r;
    logic tick_r;
    kms_state_t state_r;
    logic [8:0] timer_r;
    logic [2:0] slot_r;
    logic [2:0] row_idx_r;
    logic [1:0] hits_r;
    logic [2:0] hit_col_r;
    logic [2:0] hit_row_r;
    logic key_valid_r;
    logic [4:0] col_drive_r;
    logic key_irq_r;
    logic awready_r;
    logic wready_r;
    logic aw_hold_r;
    logic w_hold_r;
    logic [9:0] wr_idx_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    logic wr_go;
    logic wr_hit;
    logic [2:0] ncols;
    logic [2:0] nrows;
    logic [4:0] col_act;
    logic [5:0] row_act;
    logic any_low;
    logic [2:0] slot_col;
    logic slot_ok;
    logic [8:0] db_len;
    logic [8:0] sc_len;
    logic [31:0] rd_data;
    logic rd_ok;

    assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
    assign ncols = clamp(matrix_size_reg_r[2:0], 3'(KMS_NCOL));
    assign nrows = clamp(matrix_size_reg_r[KMS_SIZE_ROW_LSB +: 3], 3'(KMS_NROW));
    assign db_len = db_ticks(scan_timing_reg_r[KMS_DBT_LSB +: 6]);
    assign sc_len = sc_ticks(scan_timing_reg_r[1:0]);

    always_comb begin
        for (int i = 0; i < KMS_NCOL; i++) begin
            col_act[i] = 3'(i) < ncols;
        end
        for (int i = 0; i < KMS_NROW; i++) begin
            row_act[i] = 3'(i) < nrows;
        end
    end

    assign any_low = |(~row_s_r & row_act);

    // order slots: low holds slots 0..1, high holds slots 2..4
    always_comb begin
        unique case (slot_r)
            3'h0: slot_col = drive_order_low_reg_r[2:0];
            3'h1: slot_col = drive_order_low_reg_r[KMS_SLOT_STRIDE +: 3];
            3'h2: slot_col = drive_order_high_reg_r[2:0];
            3'h3: slot_col = drive_order_high_reg_r[KMS_SLOT_STRIDE +: 3];
            default: slot_col = drive_order_high_reg_r[2*KMS_SLOT_STRIDE +: 3];
        endcase
    end
    assign slot_ok = slot_col < ncols;

    // ------------------------------------------------------------
    // row synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            row_meta_r <= KMS_SENSE_RST;
            row_s_r <= KMS_SENSE_RST;
        end else begin
            row_meta_r <= row_sense;
            row_s_r <= row_meta_r;
        end
    end

    // ------------------------------------------------------------
    // 1 khz tick
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else if (!master_clock_ctrl_reg_r[KMS_MCLK_KEY_BIT]) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= (div_r == DIV_LAST);
            div_r <= (div_r == DIV_LAST) ? '0 : div_r + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // scan state machine
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= KMS_WAIT_PRESS;
            timer_r <= '0;
            slot_r <= '0;
            row_idx_r <= '0;
            hits_r <= '0;
            hit_col_r <= '0;
            hit_row_r <= '0;
            key_valid_r <= 1'b0;
        end else if (!hw_scan_enable_r) begin
            state_r <= KMS_WAIT_PRESS;
            timer_r <= '0;
            key_valid_r <= 1'b0;
        end else begin
            key_valid_r <= 1'b0;
            unique case (state_r)
                KMS_WAIT_PRESS: begin
                    timer_r <= '0;
                    if (any_low) begin
                        state_r <= KMS_PRESS_DB;
                    end
                end
                KMS_PRESS_DB: begin
                    if (tick_r) begin
                        timer_r <= timer_r + 1'b1;
                        if (timer_r == db_len - 1'b1) begin
                            timer_r <= '0;
                            slot_r <= '0;
                            row_idx_r <= '0;
                            hits_r <= '0;
                            state_r <= any_low ? KMS_SCAN : KMS_WAIT_PRESS;
                        end
                    end
                end
                KMS_SCAN: begin
                    // an unused or out-of-range slot is passed over at once
                    if (!slot_ok || tick_r) begin
                        timer_r <= timer_r + 1'b1;
                        if (!slot_ok || timer_r == sc_len - 1'b1) begin
                            timer_r <= '0;
                            if (slot_ok && !row_s_r[row_idx_r]) begin
                                hits_r <= (hits_r == 2'h2) ? hits_r : hits_r + 1'b1;
                                hit_col_r <= slot_col;
                                hit_row_r <= row_idx_r;
                            end
                            if (slot_ok && row_idx_r != nrows - 1'b1) begin
                                row_idx_r <= row_idx_r + 1'b1;
                            end else if (slot_r != 3'(KMS_NCOL - 1)) begin
                                row_idx_r <= '0;
                                slot_r <= slot_r + 1'b1;
                            end else begin
                                // last check also counts toward the total
                                key_valid_r <= (hits_r == 2'h0 && slot_ok
                                    && !row_s_r[row_idx_r])
                                    || (hits_r == 2'h1 && !(slot_ok
                                    && !row_s_r[row_idx_r]));
                                state_r <= KMS_WAIT_REL;
                            end
                        end
                    end
                end
                KMS_WAIT_REL: begin
                    timer_r <= '0;
                    if (!any_low) begin
                        state_r <= KMS_REL_DB;
                    end
                end
                KMS_REL_DB: begin
                    if (tick_r) begin
                        timer_r <= timer_r + 1'b1;
                        if (timer_r == db_len - 1'b1) begin
                            timer_r <= '0;
                            state_r <= any_low ? KMS_REL_DB : KMS_WAIT_PRESS;
                        end
                    end
                end
                default: begin
                    state_r <= KMS_WAIT_PRESS;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // key result latches
    // ------------------------------------------------------------
    // the final hit may land in the same cycle as key_valid_r rises,
    // so the latch reads the registered hit one cycle later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_latch_reg_r <= KMS_DRIVE_RST;
            sense_value_reg_r <= KMS_SENSE_RST;
        end else if (hw_scan_enable_r) begin
            if (key_valid_r) begin
                drive_latch_reg_r <= one_low(hit_col_r);
                sense_value_reg_r <= row_low(hit_row_r);
            end
        end else if (wr_go && wr_idx_r == KMS_IDX_DRIVE && wstrb_r[0]) begin
            drive_latch_reg_r <= wdata_r[4:0];
        end
    end

    // ------------------------------------------------------------
    // column pins
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            col_drive_r <= KMS_DRIVE_RST;
        end else if (!hw_scan_enable_r) begin
            col_drive_r <= drive_latch_reg_r;
        end else if (state_r == KMS_SCAN) begin
            col_drive_r <= slot_ok ? one_low(slot_col) : KMS_DRIVE_RST;
        end else begin
            col_drive_r <= ~col_act;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    assign wr_hit = wr_go && wstrb_r[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scan_timing_reg_r <= KMS_TIMING_RST;
            drive_order_low_reg_r <= KMS_ORDER_LO_RST;
            drive_order_high_reg_r <= KMS_ORDER_HI_RST;
            matrix_size_reg_r <= KMS_SIZE_RST;
            master_clock_ctrl_reg_r <= KMS_MCLK_RST;
            hw_scan_enable_r <= 1'b0;
            irq_enable_r <= 1'b0;
        end else if (wr_hit) begin
            unique case (wr_idx_r)
                KMS_IDX_TIMING: scan_timing_reg_r <= wdata_r[7:0];
                KMS_IDX_ORDER_LO: drive_order_low_reg_r <= wdata_r[7:0];
                KMS_IDX_ORDER_HI: begin
                    drive_order_high_reg_r[7:0] <= wdata_r[7:0];
                    if (wstrb_r[1]) begin
                        drive_order_high_reg_r[11:8] <= wdata_r[11:8];
                    end
                end
                KMS_IDX_SIZE: matrix_size_reg_r <= wdata_r[7:0];
                KMS_IDX_MCLK: master_clock_ctrl_reg_r <= wdata_r[7:0];
                KMS_IDX_CTRL: begin
                    hw_scan_enable_r <= wdata_r[KMS_CTRL_SCAN_BIT];
                    irq_enable_r <= wdata_r[KMS_CTRL_IEN_BIT];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // key flag and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key_flag_r <= 1'b0;
            key_irq_r <= 1'b0;
        end else begin
            // a new key beats a write-one clear in the same cycle
            if (key_valid_r) begin
                key_flag_r <= 1'b1;
            end else if (wr_hit && wr_idx_r == KMS_IDX_CTRL
                    && wdata_r[KMS_CTRL_DET_BIT]) begin
                key_flag_r <= 1'b0;
            end
            key_irq_r <= key_flag_r && irq_enable_r;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            wr_idx_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= KMS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                awready_r <= 1'b0;
                aw_hold_r <= 1'b1;
                wr_idx_r <= s_axi_awaddr[11:2];
            end
            if (s_axi_wvalid && wready_r) begin
                wready_r <= 1'b0;
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= (wr_idx_r >= KMS_IDX_DRIVE && wr_idx_r <= KMS_IDX_MCLK)
                    ? KMS_RESP_OKAY : KMS_RESP_SLVERR;
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    always_comb begin
        rd_data = '0;
        rd_ok = 1'b1;
        unique case (s_axi_araddr[11:2])
            KMS_IDX_DRIVE: rd_data[4:0] = drive_latch_reg_r;
            // bypass returns the live rows, scanning the latched key row
            KMS_IDX_SENSE: rd_data[5:0] = hw_scan_enable_r ? sense_value_reg_r
                : row_s_r;
            KMS_IDX_TIMING: rd_data[7:0] = scan_timing_reg_r;
            KMS_IDX_CTRL: begin
                rd_data[KMS_CTRL_IEN_BIT] = irq_enable_r;
                rd_data[KMS_CTRL_DET_BIT] = key_flag_r;
                rd_data[KMS_CTRL_SCAN_BIT] = hw_scan_enable_r;
            end
            KMS_IDX_ORDER_LO: rd_data[7:0] = drive_order_low_reg_r;
            KMS_IDX_ORDER_HI: rd_data[11:0] = drive_order_high_reg_r;
            KMS_IDX_SIZE: rd_data[7:0] = matrix_size_reg_r;
            KMS_IDX_MCLK: rd_data[7:0] = master_clock_ctrl_reg_r;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= KMS_RESP_OKAY;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_data;
            rresp_r <= rd_ok ? KMS_RESP_OKAY : KMS_RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign col_drive = col_drive_r;
    assign key_irq = key_irq_r;

endmodule // kms_keypad_scanner

// ==== logic/kms_pkg.sv ====
// constants, register map and types of the keypad matrix scanner
package kms_pkg;

    // ------------------------------------------------------------
    // matrix and timing
    // ------------------------------------------------------------
    localparam int KMS_NCOL = 5;
    localparam int KMS_NROW = 6;
    localparam int KMS_CLK_HZ = 25_000_000;
    localparam int KMS_TICK_HZ = 1000;
    localparam int KMS_TICK_CYCLES = KMS_CLK_HZ / KMS_TICK_HZ;
    localparam int KMS_TICK_MS = 1;
    localparam int KMS_DB_STEP_MS = 4;
    localparam logic [6:0] KMS_DB_ZERO_STEPS = 7'h40;
    localparam logic [2:0] KMS_SCT_ZERO_MS = 3'h4;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [9:0] KMS_IDX_DRIVE = 10'h0D1;
    localparam logic [9:0] KMS_IDX_SENSE = 10'h0D2;
    localparam logic [9:0] KMS_IDX_TIMING = 10'h0D3;
    localparam logic [9:0] KMS_IDX_CTRL = 10'h0D4;
    localparam logic [9:0] KMS_IDX_ORDER_LO = 10'h0D5;
    localparam logic [9:0] KMS_IDX_ORDER_HI = 10'h0D6;
    localparam logic [9:0] KMS_IDX_SIZE = 10'h0D7;
    localparam logic [9:0] KMS_IDX_MCLK = 10'h0D8;

    // ------------------------------------------------------------
    // reset values and fields
    // ------------------------------------------------------------
    localparam logic [4:0] KMS_DRIVE_RST = 5'h1F;
    localparam logic [5:0] KMS_SENSE_RST = 6'h3F;
    localparam logic [7:0] KMS_TIMING_RST = 8'h00;
    localparam logic [7:0] KMS_ORDER_LO_RST = 8'h10;
    localparam logic [11:0] KMS_ORDER_HI_RST = 12'h432;
    localparam logic [7:0] KMS_SIZE_RST = 8'h65;
    localparam logic [7:0] KMS_MCLK_RST = 8'h00;
    localparam int KMS_CTRL_IEN_BIT = 0;
    localparam int KMS_CTRL_DET_BIT = 1;
    localparam int KMS_CTRL_SCAN_BIT = 2;
    localparam int KMS_MCLK_KEY_BIT = 6;
    localparam int KMS_DBT_LSB = 2;
    localparam int KMS_SLOT_STRIDE = 4;
    localparam int KMS_SIZE_ROW_LSB = 4;
    localparam logic [1:0] KMS_RESP_OKAY = 2'h0;
    localparam logic [1:0] KMS_RESP_SLVERR = 2'h2;

    // usual path: wait, press debounce, scan, wait release, release debounce
    typedef enum logic [2:0] {
        KMS_WAIT_PRESS = 3'h0,
        KMS_PRESS_DB = 3'h1,
        KMS_SCAN = 3'h3,
        KMS_WAIT_REL = 3'h2,
        KMS_REL_DB = 3'h6
    } kms_state_t;

endpackage

// ==== test/kms_keypad_scanner_props.sv ====
// assertions on the bus handshakes and pins of the keypad scanner
module kms_keypad_scanner_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [4:0] col_drive,
    input wire logic key_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_reset_pins: assert property ($rose(aresetn) |-> col_drive == 5'h1F && !key_irq)
        else $error("pins not idle after reset");
    a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not released");
    a_irq_driven: assert property ($rose(key_irq) |-> col_drive != 5'h1F)
        else $error("key interrupt without driven columns");
endmodule // kms_keypad_scanner_props

bind kms_keypad_scanner kms_keypad_scanner_props i_props (.*);

// ==== test/kms_keypad_model.sv ====
// switch matrix with row pull-ups; the bench chooses the closed crossings
module kms_keypad_model (
    input wire logic [4:0] col_drive,
    input wire logic [29:0] closed,
    output logic [5:0] row_sense
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        row_sense = 6'h3F;
        for (int c = 0; c < 5; c++) begin
            for (int r = 0; r < 6; r++) begin
                if (!col_drive[c] && closed[c * 6 + r]) row_sense[r] = 1'b0;
            end
        end
    end
endmodule // kms_keypad_model

// ==== test/tb.sv ====
// self-checking bench for the keypad matrix scanner
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, key_irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [4:0] col_drive;
    logic [5:0] row_sense;
    logic [29:0] closed = 30'h0;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    always #20 aclk = ~aclk;
    // short tick keeps a 4 ms debounce at 40 cycles
    kms_keypad_scanner #(.TICK_CYCLES(10)) i_dut (.*);
    kms_keypad_model i_keys (.*);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw;
        bit w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) aw = 1'b0;
            if (s_axi_wready) w = 1'b0;
            if (!aw) s_axi_awvalid <= 1'b0;
            if (!w) s_axi_wvalid <= 1'b0;
        end while (aw || w);
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(er), 32'(s_axi_bresp));
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
    endtask
    task automatic summarize();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        chk("col_drive", 32'h1F, 32'(col_drive));
        rd(12'h344, 32'h1F, 2'h0);
        rd(12'h348, 32'h3F, 2'h0);
        wr(12'h400, 32'h5, 2'h2);
        rd(12'h400, 32'h0, 2'h2);
        wr(12'h344, 32'h1E, 2'h0);
        closed <= 30'h1;
        repeat (4) @(posedge aclk);
        chk("col_drive", 32'h1E, 32'(col_drive));
        rd(12'h348, 32'h3E, 2'h0);
        wr(12'h344, 32'h0F, 2'h0);
        closed <= 30'h1 << 29;
        repeat (4) @(posedge aclk);
        chk("col_drive", 32'h0F, 32'(col_drive));
        rd(12'h348, 32'h1F, 2'h0);
        closed <= 30'h0;
        wr(12'h34C, 32'h05, 2'h0);
        wr(12'h350, 32'h05, 2'h0);
        repeat (4) @(posedge aclk);
        chk("col_drive", 32'h00, 32'(col_drive));
        closed <= 30'h1 << 15;
        repeat (200) @(posedge aclk);
        chk("key_irq", 32'h0, 32'(key_irq));
        wr(12'h360, 32'h40, 2'h0);
        repeat (2000) if (key_irq !== 1'b1) @(posedge aclk);
        chk("key_irq", 32'h1, 32'(key_irq));
        rd(12'h344, 32'h1B, 2'h0);
        rd(12'h348, 32'h37, 2'h0);
        closed <= 30'h0;
        repeat (100) @(posedge aclk);
        closed <= 30'h1 << 24;
        // debounce, then thirty row checks of one tick each
        repeat (600) @(posedge aclk);
        rd(12'h344, 32'h0F, 2'h0);
        rd(12'h348, 32'h3E, 2'h0);
        closed <= 30'h0;
        repeat (100) @(posedge aclk);
        closed <= (30'h1 << 7) | (30'h1 << 20);
        repeat (600) @(posedge aclk);
        rd(12'h344, 32'h0F, 2'h0);
        wr(12'h350, 32'h01, 2'h0);
        repeat (2) @(posedge aclk);
        chk("col_drive", 32'h0F, 32'(col_drive));
        wr(12'h354, 32'h01, 2'h0);
        wr(12'h358, 32'h234, 2'h0);
        rd(12'h354, 32'h01, 2'h0);
        rd(12'h358, 32'h234, 2'h0);
        rd(12'h35C, 32'h65, 2'h0);
        wr(12'h350, 32'h02, 2'h0);
        repeat (2) @(posedge aclk);
        chk("key_irq", 32'h0, 32'(key_irq));
        summarize();
    end
endmodule // tb
